// File: inc/hsc_defines.svh
// timing counts, widths and reset values of the hot-swap startup block
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define HSC_NCH          4
`define HSC_ADC_W        10
`define HSC_PIN_W        16

// ----------------------------------------------------------------------
// pin vector field positions
// ----------------------------------------------------------------------
`define HSC_PIN_SUPPLY   0
`define HSC_PIN_HARDWARE_ENABLE_STRAP     1
`define HSC_PIN_PROTECTION_STRAP_LO  2
`define HSC_PIN_MODE_LO  4
`define HSC_PIN_POL      6
`define HSC_PIN_RETRY    7
`define HSC_PIN_ON_LO    8
`define HSC_PIN_TRIP_LO  12

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define HSC_CLK_MHZ      200
`define HSC_RETRY_MS     200
`define HSC_RETRY_CYCLES (`HSC_RETRY_MS * 1000 * `HSC_CLK_MHZ)
`define HSC_RETRY_CNT_W  26

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define HSC_RST_POL      1'b1
`define HSC_RST_RETRY    1'b0

`endif

// File: inc/hsc_pkg.sv
// types of the hot-swap startup block
package hsc_pkg;

	// ------------------------------------------------------------------
	// startup sequence states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		HSC_ST_OFF  = 3'b001,
		HSC_ST_LOAD = 3'b010,
		HSC_ST_RUN  = 3'b100
	} hsc_state_e;

	// ------------------------------------------------------------------
	// decoded three-level strap code
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		HSC_STRAP_LOW  = 2'h0,
		HSC_STRAP_HIGH = 2'h1,
		HSC_STRAP_OPEN = 2'h2
	} hsc_strap_e;

endpackage

// File: verilog/hsc_startup.sv
// startup configuration and channel enable logic of a quad hot-swap controller
`timescale 1ns/1ps
`include "hsc_defines.svh"

module hsc_startup #(
	parameter int RETRY_CYCLES = `HSC_RETRY_CYCLES,
	parameter int CNT_W        = `HSC_RETRY_CNT_W
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  supply_good,
	input  wire logic                  hardware_enable_strap,
	input  wire logic [1:0]            protection_strap,
	input  wire logic [1:0]            grouping_strap,
	input  wire logic                  power_good_polarity_strap,
	input  wire logic                  retry_strap,
	input  wire logic [3:0]            on_comparator,
	input  wire logic [3:0]            breaker_trip,
	input  wire logic [3:0]            enable_bit_a,
	input  wire logic [3:0]            enable_b_write,
	input  wire logic [3:0]            enable_b_value,
	input  wire logic                  alert_clear,
	input  wire logic                  adc_valid,
	input  wire logic                  adc_is_current,
	input  wire logic [1:0]            adc_channel,
	input  wire logic [`HSC_ADC_W-1:0] adc_data,
	input  wire logic [`HSC_ADC_W-1:0] warn_uv_limit,
	input  wire logic [`HSC_ADC_W-1:0] warn_ov_limit,
	input  wire logic [`HSC_ADC_W-1:0] crit_uv_limit,
	input  wire logic [`HSC_ADC_W-1:0] crit_ov_limit,
	input  wire logic [`HSC_ADC_W-1:0] oc_warn_limit,
	output logic      [3:0]            gate_request,
	output logic      [3:0]            power_good_out,
	output logic      [3:0]            fault_out_n,
	output logic                       alert_out_n,
	output logic      [3:0]            enable_bit_b,
	output logic      [3:0]            on_status,
	output logic                       channel_control_active,
	output logic      [1:0]            group_mode
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [3:0] group_mask(input int ch, input logic [1:0] mode);
		logic [3:0] m;
		m = 4'h0;
		case (mode)
			hsc_pkg::HSC_STRAP_HIGH: m = ch[0] ? 4'ha : 4'h5;
			hsc_pkg::HSC_STRAP_OPEN: m = 4'hf;
			default:                 m = 4'(4'h1 << ch);
		endcase
		return m;
	endfunction

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [`HSC_PIN_W-1:0] pin_meta;
	logic [`HSC_PIN_W-1:0] pin_sync;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_meta <= 16'h0;
			pin_sync <= 16'h0;
		end else begin
			pin_meta <= {breaker_trip, on_comparator, retry_strap, power_good_polarity_strap,
				grouping_strap, protection_strap, hardware_enable_strap, supply_good};
			pin_sync <= pin_meta;
		end
	end

	logic       sup_good;
	logic [3:0] on_pin;
	logic [3:0] trip_pin;
	assign sup_good = pin_sync[`HSC_PIN_SUPPLY];
	assign on_pin   = pin_sync[`HSC_PIN_ON_LO +: 4];
	assign trip_pin = pin_sync[`HSC_PIN_TRIP_LO +: 4];

	// ------------------------------------------------------------------
	// startup sequence
	// ------------------------------------------------------------------
	hsc_pkg::hsc_state_e state;
	logic [1:0]          protection_strap_mode;
	logic                pol_high;
	logic                retry_auto;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= hsc_pkg::HSC_ST_OFF;
		end else if (!sup_good) begin
			state <= hsc_pkg::HSC_ST_OFF;
		end else begin
			case (state)
				hsc_pkg::HSC_ST_OFF:  state <= hsc_pkg::HSC_ST_LOAD;
				hsc_pkg::HSC_ST_LOAD: state <= hsc_pkg::HSC_ST_RUN;
				default:              state <= hsc_pkg::HSC_ST_RUN;
			endcase
		end
	end

	// straps caught once; a jumper moved later has no effect until power cycles
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			protection_strap_mode  <= hsc_pkg::HSC_STRAP_LOW;
			group_mode <= hsc_pkg::HSC_STRAP_LOW;
			pol_high   <= `HSC_RST_POL;
			retry_auto <= `HSC_RST_RETRY;
		end else if (state == hsc_pkg::HSC_ST_LOAD) begin
			protection_strap_mode  <= pin_sync[`HSC_PIN_PROTECTION_STRAP_LO +: 2];
			group_mode <= pin_sync[`HSC_PIN_MODE_LO +: 2];
			pol_high   <= pin_sync[`HSC_PIN_POL];
			retry_auto <= pin_sync[`HSC_PIN_RETRY];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			channel_control_active <= 1'b0;
		end else begin
			channel_control_active <= (state == hsc_pkg::HSC_ST_RUN);
		end
	end

	// ------------------------------------------------------------------
	// enable bits and on status
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_bit_b <= 4'h0;
		end else if (state == hsc_pkg::HSC_ST_LOAD) begin
			enable_bit_b <= {4{pin_sync[`HSC_PIN_HARDWARE_ENABLE_STRAP]}};
		end else if (state == hsc_pkg::HSC_ST_RUN) begin
			enable_bit_b <= (enable_bit_b & ~enable_b_write)
				| (enable_b_value & enable_b_write);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			on_status <= 4'h0;
		end else begin
			on_status <= on_pin;
		end
	end

	logic [3:0] chan_req;
	assign chan_req = on_status & (enable_bit_a | enable_bit_b);

	// ------------------------------------------------------------------
	// converter results and limit checks
	// ------------------------------------------------------------------
	logic [`HSC_ADC_W-1:0] volt [4];
	logic [`HSC_ADC_W-1:0] curr [4];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `HSC_NCH; i++) begin
				volt[i] <= 10'h0;
				curr[i] <= 10'h0;
			end
		end else if (adc_valid) begin
			if (adc_is_current) begin
				curr[adc_channel] <= adc_data;
			end else begin
				volt[adc_channel] <= adc_data;
			end
		end
	end

	logic [3:0] in_warn;
	logic [3:0] crit;
	logic [3:0] oc_warn;
	always_comb begin
		for (int i = 0; i < `HSC_NCH; i++) begin
			in_warn[i] = (volt[i] >= warn_uv_limit) && (volt[i] <= warn_ov_limit);
			crit[i]    = (volt[i] < crit_uv_limit) || (volt[i] > crit_ov_limit);
			oc_warn[i] = curr[i] > oc_warn_limit;
		end
	end

	// ------------------------------------------------------------------
	// shutdown, retry and fault outputs
	// ------------------------------------------------------------------
	logic [3:0]       tripped;
	logic [3:0]       trip_now;
	logic [CNT_W-1:0] wait_cnt [4];

	// only a conducting channel can trip; an off channel always reads undervoltage
	assign trip_now = gate_request & (trip_pin
		| (crit & {4{protection_strap_mode == hsc_pkg::HSC_STRAP_LOW}}));

	always_ff @(posedge clk) begin
		if (sys_rst || state != hsc_pkg::HSC_ST_RUN) begin
			tripped     <= 4'h0;
			fault_out_n <= 4'hf;
			for (int i = 0; i < `HSC_NCH; i++) begin
				wait_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < `HSC_NCH; i++) begin
				if (trip_now[i]) begin
					tripped[i] <= 1'b1;
					wait_cnt[i] <= '0;
					if (trip_pin[i]) begin
						fault_out_n[i] <= 1'b0;
					end
				end else if (tripped[i] && retry_auto) begin
					if (wait_cnt[i] == CNT_W'(RETRY_CYCLES - 1)) begin
						tripped[i]     <= 1'b0;
						fault_out_n[i] <= 1'b1;
						wait_cnt[i]    <= '0;
					end else begin
						wait_cnt[i] <= wait_cnt[i] + CNT_W'(1);
					end
				end else if (tripped[i] && !chan_req[i]) begin
					tripped[i]     <= 1'b0;
					fault_out_n[i] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// gate requests and power good
	// ------------------------------------------------------------------
	logic [3:0] next_gate;
	logic [3:0] pg_active;
	logic [3:0] next_pg;
	always_comb begin
		for (int i = 0; i < `HSC_NCH; i++) begin
			next_gate[i] = (state == hsc_pkg::HSC_ST_RUN)
				&& (&(chan_req | ~group_mask(i, group_mode)))
				&& !(|(tripped & group_mask(i, group_mode)));
			pg_active[i] = gate_request[i] && in_warn[i]
				&& !(crit[i] && protection_strap_mode != hsc_pkg::HSC_STRAP_OPEN);
			next_pg[i] = pol_high ? pg_active[i] : !pg_active[i];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gate_request   <= 4'h0;
			power_good_out <= 4'h0;
		end else begin
			gate_request   <= next_gate;
			power_good_out <= next_pg;
		end
	end

	// ------------------------------------------------------------------
	// alert
	// ------------------------------------------------------------------
	logic pg_seen;
	logic alert;
	logic next_alert_set;

	assign next_alert_set = (|(crit & gate_request))
		|| (pg_seen && |(gate_request & (~in_warn | oc_warn | trip_pin)));

	always_ff @(posedge clk) begin
		if (sys_rst || state == hsc_pkg::HSC_ST_OFF) begin
			pg_seen <= 1'b0;
		end else if (|pg_active) begin
			pg_seen <= 1'b1;
		end
	end

	// a breach in the clearing cycle keeps the alert standing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alert       <= 1'b0;
			alert_out_n <= 1'b1;
		end else begin
			alert       <= next_alert_set || (alert && !alert_clear);
			alert_out_n <= !(next_alert_set || (alert && !alert_clear));
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence seq_ch0_crit_low;
		state == hsc_pkg::HSC_ST_RUN && protection_strap_mode == hsc_pkg::HSC_STRAP_LOW
			&& gate_request[0] && crit[0];
	endsequence

	sequence seq_ch0_trip;
		state == hsc_pkg::HSC_ST_RUN && gate_request[0] && trip_pin[0];
	endsequence

	AST_OFF_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
		state == hsc_pkg::HSC_ST_OFF |=> gate_request == 4'h0)
		else $error("gate requested while supply not good");
	AST_HARDWARE_ENABLE_STRAP_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
		state == hsc_pkg::HSC_ST_LOAD |=> enable_bit_b == {4{$past(pin_sync[1])}})
		else $error("second enable bits do not follow strap");
	AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		state == hsc_pkg::HSC_ST_RUN ##1 state == hsc_pkg::HSC_ST_RUN
		|-> $stable(protection_strap_mode) && $stable(group_mode))
		else $error("strap setting changed after startup");
	AST_GATE_NEEDS_ON: assert property (@(posedge clk) disable iff (sys_rst)
		(gate_request & ~$past(on_status)) == 4'h0)
		else $error("gate on without on status");
	AST_ALERT_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
		!alert_out_n && !alert_clear |=> !alert_out_n)
		else $error("alert dropped without clear");
	AST_CRIT_SHUT: assert property (@(posedge clk) disable iff (sys_rst)
		seq_ch0_crit_low |-> ##[1:2] !gate_request[0])
		else $error("critical fault did not shut channel");
	AST_TRIP_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
		seq_ch0_trip |=> !fault_out_n[0] ##1 !gate_request[0])
		else $error("breaker trip without fault output");
	AST_PG_POLARITY: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> power_good_out[0] == ($past(pol_high) ~^ $past(pg_active[0])))
		else $error("power good polarity wrong");

endmodule

// File: testbench/hsc_partner.sv
// model of the channel supplies and gate drivers facing the startup block
`timescale 1ns/1ps

module hsc_partner (
	input  wire logic       clk,
	input  wire logic [3:0] gate_request,
	input  wire logic [3:0] supply_up,
	input  wire logic [3:0] overload,
	output logic      [3:0] on_comparator,
	output logic      [3:0] breaker_trip
);
	// ----------------------------------------------------------------
	// on comparators and breakers
	// ----------------------------------------------------------------
	// divider output sits above threshold once the channel supply is up
	assign on_comparator = supply_up;

	// no current flows through an off mosfet, so an idle channel never trips
	always_ff @(posedge clk) begin
		breaker_trip <= gate_request & overload;
	end
endmodule

// File: testbench/test_hot_swap_startup_config.sv
// self-checking bench of the hot-swap startup block
`timescale 1ns/1ps
`include "hsc_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module test_hot_swap_startup_config;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int RETRY = 20;
	logic                  clk, sys_rst, supply_good, hardware_enable_strap;
	logic                  power_good_polarity_strap, retry_strap, alert_clear;
	logic                  adc_valid, adc_is_current, alert_out_n, channel_control_active;
	logic [1:0]            protection_strap, grouping_strap, adc_channel, group_mode;
	logic [3:0]            on_comparator, breaker_trip, enable_bit_a, enable_b_write;
	logic [3:0]            enable_b_value, gate_request, power_good_out, fault_out_n;
	logic [3:0]            enable_bit_b, on_status, supply_up, overload, model_b;
	logic [`HSC_ADC_W-1:0] adc_data, warn_ov_limit, oc_warn_limit;
	int                    failures, total_checks, cycles, seed;

	hsc_startup #(.RETRY_CYCLES(RETRY), .CNT_W(8)) u_hsc_startup (.clk, .sys_rst,
		.supply_good, .hardware_enable_strap, .protection_strap, .grouping_strap,
		.power_good_polarity_strap, .retry_strap, .on_comparator, .breaker_trip,
		.enable_bit_a, .enable_b_write, .enable_b_value, .alert_clear, .adc_valid,
		.adc_is_current, .adc_channel, .adc_data, .warn_uv_limit(10'h12c),
		.warn_ov_limit, .crit_uv_limit(10'h064), .crit_ov_limit(10'h384),
		.oc_warn_limit, .gate_request, .power_good_out, .fault_out_n,
		.alert_out_n, .enable_bit_b, .on_status, .channel_control_active, .group_mode);

	hsc_partner u_hsc_partner (.clk, .gate_request, .supply_up, .overload,
		.on_comparator, .breaker_trip);

	// ----------------------------------------------------------------
	// clock, timeout and tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic startup(input logic hw, input logic [1:0] pr, input logic [1:0] gr,
		input logic po, input logic re);
		supply_good = 1'b0;
		tick(4);
		{hardware_enable_strap, protection_strap, grouping_strap} = {hw, pr, gr};
		{power_good_polarity_strap, retry_strap} = {po, re};
		supply_good = 1'b1;
		tick(6);
	endtask

	// voltage result for each channel set in chans, one pulse each
	task automatic volt(input logic [3:0] chans, input logic [9:0] v);
		for (int c = 0; c < 4; c++) begin
			if (chans[c]) begin
				{adc_valid, adc_channel, adc_data} = {1'b1, 2'(c), v};
				tick(1);
			end
		end
		adc_valid = 1'b0;
		tick(3);
	endtask

	task automatic clear_alert();
		alert_clear = 1'b1;
		tick(1);
		alert_clear = 1'b0;
		tick(2);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h545461fc;
		{sys_rst, supply_good, hardware_enable_strap, protection_strap} = 5'h10;
		{grouping_strap, power_good_polarity_strap, retry_strap, alert_clear} = 5'h0;
		{adc_valid, adc_is_current, adc_channel, adc_data} = 14'h0;
		{enable_bit_a, enable_b_write, enable_b_value, supply_up, overload} = 20'h0;
		{failures, total_checks, cycles} = 0;
		{warn_ov_limit, oc_warn_limit} = {10'h2bc, 10'h3e8};
		tick(10);
		sys_rst = 1'b0;
		supply_up = 4'hf;
		enable_bit_a = 4'hf;
		// stored voltages start at zero, which reads as critical once a gate opens
		volt(4'hf, 10'h1f4);
		`CHK(gate_request, 4'h0)
		`CHK(channel_control_active, 1'b0)
		startup(1'b1, 2'h0, 2'h0, 1'b1, 1'b1);
		`CHK(channel_control_active, 1'b1)
		`CHK(enable_bit_b, 4'hf)
		`CHK(group_mode, 2'h0)
		// later strap moves must leave the captured settings alone
		{hardware_enable_strap, protection_strap, grouping_strap} = 5'h06;
		model_b = 4'hf;
		for (int i = 0; i < 40; i++) begin
			supply_up = 4'($random(seed));
			enable_bit_a = 4'($random(seed));
			enable_b_write = 4'($random(seed));
			enable_b_value = 4'($random(seed));
			model_b = (model_b & ~enable_b_write) | (enable_b_write & enable_b_value);
			tick(1);
			enable_b_write = 4'h0;
			tick(6);
			`CHK(enable_bit_b, model_b)
			`CHK(on_status, supply_up)
			`CHK(gate_request, supply_up & (enable_bit_a | model_b))
		end
		`CHK(group_mode, 2'h0)
		{supply_up, enable_bit_a} = 8'hff;
		tick(6);
		volt(4'hf, 10'h1f4);
		`CHK(power_good_out, 4'hf)
		`CHK(alert_out_n, 1'b1)
		overload = 4'h1;
		tick(6);
		overload = 4'h0;
		`CHK(fault_out_n, 4'he)
		`CHK(gate_request, 4'he)
		`CHK(alert_out_n, 1'b0)
		tick(RETRY + 8);
		`CHK(fault_out_n, 4'hf)
		`CHK(gate_request, 4'hf)
		`CHK(alert_out_n, 1'b0)
		clear_alert();
		`CHK(alert_out_n, 1'b1)
		volt(4'h1, 10'h3b6);
		`CHK(gate_request, 4'he)
		`CHK(power_good_out[0], 1'b0)
		`CHK(alert_out_n, 1'b0)
		`CHK(fault_out_n, 4'hf)
		volt(4'h1, 10'h1f4);
		tick(RETRY + 8);
		clear_alert();
		`CHK(gate_request, 4'hf)
		// overcurrent warning on a conducting channel
		adc_is_current = 1'b1;
		volt(4'h1, 10'h3f0);
		`CHK(alert_out_n, 1'b0)
		`CHK(gate_request, 4'hf)
		volt(4'h1, 10'h000);
		adc_is_current = 1'b0;
		clear_alert();
		`CHK(alert_out_n, 1'b1)
		// second power-up with every strap moved
		{supply_up, enable_bit_a} = 8'h0;
		startup(1'b0, 2'h1, 2'h2, 1'b0, 1'b0);
		`CHK(enable_bit_b, 4'h0)
		`CHK(group_mode, 2'h2)
		{supply_up, enable_bit_a} = 8'h7f;
		tick(6);
		`CHK(gate_request, 4'h0)
		supply_up = 4'hf;
		tick(6);
		`CHK(gate_request, 4'hf)
		volt(4'hf, 10'h1f4);
		`CHK(power_good_out, 4'h0)
		volt(4'h4, 10'h032);
		`CHK(gate_request, 4'hf)
		`CHK(power_good_out[2], 1'b1)
		`CHK(alert_out_n, 1'b0)
		volt(4'h4, 10'h1f4);
		clear_alert();
		overload = 4'h8;
		tick(6);
		overload = 4'h0;
		tick(RETRY + 8);
		`CHK(fault_out_n, 4'h7)
		`CHK(gate_request, 4'h0)
		enable_bit_a = 4'h0;
		tick(6);
		enable_bit_a = 4'hf;
		tick(8);
		`CHK(fault_out_n, 4'hf)
		`CHK(gate_request, 4'hf)
		// third power-up: paired channels, protection strap open
		clear_alert();
		startup(1'b1, 2'h2, 2'h1, 1'b1, 1'b1);
		`CHK(group_mode, 2'h1)
		supply_up = 4'hb;
		tick(6);
		`CHK(gate_request, 4'ha)
		supply_up = 4'hf;
		tick(6);
		`CHK(alert_out_n, 1'b1)
		volt(4'h2, 10'h3b6);
		`CHK(gate_request, 4'hf)
		`CHK(alert_out_n, 1'b0)
		`CHK(fault_out_n, 4'hf)
		volt(4'h2, 10'h1f4);
		wrap_up();
	end
endmodule
